// ===== ldo_rail_control_regs.sv
// Serial register slave and register bank for two linear regulator rails
// How it works
// - Select bit 0: rail on/off follows the power sequencer request, inverted when SEQ_INVERT is set.
// - Select bit 1: rail follows the software enable bit only.
// - Control registers 0x5E, 0x60 reset 0x00; enable bit0, select bit1.
// - Voltage code registers at 0x16, 0x17, loaded from OTP after reset.
// - Target is 1000 mV plus 25 mV per code step, 0x1A is 1650 mV.
// - Sequencing registers at 0xF0, 0xF1, OTP loaded, type 5:4, group 3:0.
// - Type field 00 A, 01 U, 10 S, 11 SX for the sequencer.
// - Group field is a binary delay group number 0 to 14.
`include "rail_params.svh"
`default_nettype none

module ldo_rail_control_regs
    import rail_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2A, // Arbitrary bus address
    parameter bit SEQ_INVERT = 1'b0
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Serial register bus pins, SDA open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // One-time-programmable defaults, sampled after reset release
    input wire logic [`VCODE_MSB:0] otp_rail3_vcode_i,
    input wire logic [`VCODE_MSB:0] otp_rail4_vcode_i,
    input wire logic [`GRP_MSB:0] otp_rail3_grp_i,
    input wire logic [`GRP_MSB:0] otp_rail4_grp_i,
    // Power sequencer requests
    input wire logic rail3_seq_on_i,
    input wire logic rail4_seq_on_i,
    // Rail 3 outputs
    output logic rail3_on_o,
    output logic [`VCODE_MSB:0] rail3_vcode_o,
    output logic [11:0] rail3_target_mv_o,
    output logic rail3_mv_in_range_o,
    output rail_class_t rail3_class_o,
    output logic [3:0] rail3_group_o,
    // Rail 4 outputs
    output logic rail4_on_o,
    output logic [`VCODE_MSB:0] rail4_vcode_o,
    output logic [11:0] rail4_target_mv_o,
    output logic rail4_mv_in_range_o,
    output rail_class_t rail4_class_o,
    output logic [3:0] rail4_group_o
);

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic scl_f;
    logic sda_f;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    i2c_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] reg_ptr;
    logic read_mode;
    logic master_nack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic otp_done;
    logic [1:0] rail3_onoff_control;
    logic [1:0] rail4_onoff_control;
    logic [`GRP_MSB:0] rail3_sequence_group;
    logic [`GRP_MSB:0] rail4_sequence_group;

    // Reset released through two flops to avoid release races
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pin synchronisers; level taken only when stages two and three agree
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 3'b111;
            sda_q <= 3'b111;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
            if (scl_q[1] == scl_q[2]) begin
                scl_f <= scl_q[2];
            end
            if (sda_q[1] == sda_q[2]) begin
                sda_f <= sda_q[2];
            end
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end

    // Bus events on the filtered levels
    assign scl_rise = scl_f && !scl_prev;
    assign scl_fall = !scl_f && scl_prev;
    assign start_seen = scl_f && scl_prev && sda_prev && !sda_f;
    assign stop_seen = scl_f && scl_prev && !sda_prev && sda_f;

    // Read mux; unmapped addresses read zero, reserved bits too
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        case (addr)
            `RAIL3_CTL_ADDR: read_reg = {6'h00, rail3_onoff_control};
            `RAIL4_CTL_ADDR: read_reg = {6'h00, rail4_onoff_control};
            `RAIL3_VCODE_ADDR: read_reg = {2'h0, rail3_vcode_o};
            `RAIL4_VCODE_ADDR: read_reg = {2'h0, rail4_vcode_o};
            `RAIL3_GRP_ADDR: read_reg = {2'h0, rail3_sequence_group};
            `RAIL4_GRP_ADDR: read_reg = {2'h0, rail4_sequence_group};
            default: read_reg = `BYTE_ZERO;
        endcase
    endfunction : read_reg

    assign rd_data = read_reg(reg_ptr);

    // Open-drain data line only ever pulls low
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // Serial slave: address, pointer, auto-incrementing data bytes
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= `BYTE_ZERO;
            tx_shift <= `BYTE_ZERO;
            reg_ptr <= `BYTE_ZERO;
            read_mode <= 1'b0;
            master_nack <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= `BYTE_ZERO;
            wr_data <= `BYTE_ZERO;
        end else begin
            wr_en <= 1'b0;
            if (start_seen) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        rx_shift <= {rx_shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + `BIT_ONE;
                    end
                    ST_RDATA_ACK: begin
                        master_nack <= sda_f;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            if (rx_shift[7:1] == DEVICE_ADDR) begin
                                read_mode <= rx_shift[0];
                                sda_oe_o <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        bit_cnt <= 4'h0;
                        if (read_mode) begin
                            // First data bit goes out at once
                            sda_oe_o <= ~rd_data[7];
                            tx_shift <= {rd_data[6:0], 1'b0};
                            bit_cnt <= `BIT_ONE;
                            state <= ST_RDATA;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            reg_ptr <= rx_shift;
                            sda_oe_o <= 1'b1;
                            state <= ST_PTR_ACK;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            wr_en <= 1'b1;
                            wr_addr <= reg_ptr;
                            wr_data <= rx_shift;
                            reg_ptr <= reg_ptr + 8'h01;
                            sda_oe_o <= 1'b1;
                            state <= ST_WDATA_ACK;
                        end
                    end
                    ST_PTR_ACK, ST_WDATA_ACK: begin
                        sda_oe_o <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            sda_oe_o <= 1'b0;
                            reg_ptr <= reg_ptr + 8'h01;
                            state <= ST_RDATA_ACK;
                        end else begin
                            sda_oe_o <= ~tx_shift[7];
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            bit_cnt <= bit_cnt + `BIT_ONE;
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (master_nack) begin
                            state <= ST_IDLE;
                        end else begin
                            sda_oe_o <= ~rd_data[7];
                            tx_shift <= {rd_data[6:0], 1'b0};
                            bit_cnt <= `BIT_ONE;
                            state <= ST_RDATA;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // OTP defaults captured once, the first cycle after reset release
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            otp_done <= 1'b0;
        end else begin
            otp_done <= 1'b1;
        end
    end

    // Control registers; only enable and select bits are stored
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rail3_onoff_control <= `CTL_RESET;
            rail4_onoff_control <= `CTL_RESET;
        end else if (wr_en) begin
            if (wr_addr == `RAIL3_CTL_ADDR) begin
                rail3_onoff_control <= wr_data[1:0];
            end
            if (wr_addr == `RAIL4_CTL_ADDR) begin
                rail4_onoff_control <= wr_data[1:0];
            end
        end
    end

    // Voltage code registers; OTP load wins over a same-cycle write
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rail3_vcode_o <= `VCODE_RESET;
            rail4_vcode_o <= `VCODE_RESET;
        end else if (!otp_done) begin
            rail3_vcode_o <= otp_rail3_vcode_i;
            rail4_vcode_o <= otp_rail4_vcode_i;
        end else if (wr_en) begin
            if (wr_addr == `RAIL3_VCODE_ADDR) begin
                rail3_vcode_o <= wr_data[`VCODE_MSB:0];
            end
            if (wr_addr == `RAIL4_VCODE_ADDR) begin
                rail4_vcode_o <= wr_data[`VCODE_MSB:0];
            end
        end
    end

    // Sequencing registers; bits 7:6 are not stored
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rail3_sequence_group <= `GRP_RESET;
            rail4_sequence_group <= `GRP_RESET;
        end else if (!otp_done) begin
            rail3_sequence_group <= otp_rail3_grp_i;
            rail4_sequence_group <= otp_rail4_grp_i;
        end else if (wr_en) begin
            if (wr_addr == `RAIL3_GRP_ADDR) begin
                rail3_sequence_group <= wr_data[`GRP_MSB:0];
            end
            if (wr_addr == `RAIL4_GRP_ADDR) begin
                rail4_sequence_group <= wr_data[`GRP_MSB:0];
            end
        end
    end

    // Rail 3 selection and decode
    rail_select #(
        .SEQ_INVERT(SEQ_INVERT)
    ) rail3_sel (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .source_select_i(rail3_onoff_control[`CTL_SEL_BIT]),
        .software_enable_i(rail3_onoff_control[`CTL_EN_BIT]),
        .vcode_i(rail3_vcode_o),
        .grp_i(rail3_sequence_group),
        .seq_on_i(rail3_seq_on_i),
        .rail_on_o(rail3_on_o),
        .target_mv_o(rail3_target_mv_o),
        .mv_in_range_o(rail3_mv_in_range_o),
        .class_o(rail3_class_o),
        .group_o(rail3_group_o)
    );

    // Rail 4 selection and decode
    rail_select #(
        .SEQ_INVERT(SEQ_INVERT)
    ) rail4_sel (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .source_select_i(rail4_onoff_control[`CTL_SEL_BIT]),
        .software_enable_i(rail4_onoff_control[`CTL_EN_BIT]),
        .vcode_i(rail4_vcode_o),
        .grp_i(rail4_sequence_group),
        .seq_on_i(rail4_seq_on_i),
        .rail_on_o(rail4_on_o),
        .target_mv_o(rail4_target_mv_o),
        .mv_in_range_o(rail4_mv_in_range_o),
        .class_o(rail4_class_o),
        .group_o(rail4_group_o)
    );

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    a_ctl_write_lands: assert property (
        wr_en && wr_addr == `RAIL4_CTL_ADDR
        |=> rail4_onoff_control == $past(wr_data[1:0]))
        else $error("control write not stored");

    a_ctl_reserved_zero: assert property (
        reg_ptr == `RAIL3_CTL_ADDR |-> rd_data[7:2] == 6'h00)
        else $error("control reserved bits not zero");

    a_grp_reserved_zero: assert property (
        reg_ptr == `RAIL4_GRP_ADDR |-> rd_data[7:6] == 2'h0)
        else $error("sequencing reserved bits not zero");

    a_otp_loads_defaults: assert property (
        rst_n && !otp_done |=> rail3_vcode_o == $past(otp_rail3_vcode_i)
            && rail4_sequence_group == $past(otp_rail4_grp_i))
        else $error("OTP defaults not loaded");

    a_otp_load_once: assert property (
        otp_done && !wr_en |=> $stable(rail3_sequence_group))
        else $error("sequencing register changed without write");

    a_vcode_readback: assert property (
        wr_en && wr_addr == `RAIL3_VCODE_ADDR && otp_done
        |=> {2'h0, rail3_vcode_o} ==
            {2'h0, $past(wr_data[`VCODE_MSB:0])})
        else $error("voltage code does not read back");

    a_addr_ack_drive: assert property (
        scl_fall && state == ST_ADDR && bit_cnt == `BYTE_BITS
        && rx_shift[7:1] == DEVICE_ADDR && !start_seen && !stop_seen
        |=> sda_oe_o && state == ST_ADDR_ACK)
        else $error("own address not acknowledged");

    a_sw_select_path: assert property (
        rail3_onoff_control == 2'h2 ##1 rail3_onoff_control == 2'h2
        |-> !rail3_on_o)
        else $error("software off not honoured");

    c_ctl_write: cover property (wr_en && wr_addr == `RAIL3_CTL_ADDR);
    c_read_byte: cover property (state == ST_RDATA ##[1:400] state ==
        ST_RDATA_ACK);
    c_rail4_on: cover property ($rose(rail4_on_o));

endmodule : ldo_rail_control_regs

`default_nettype wire

// ===== rail_params.svh
// Register map, field positions and timing-free constants for the rail bank
`ifndef RAIL_PARAMS_SVH
`define RAIL_PARAMS_SVH

// Register addresses
`define RAIL3_VCODE_ADDR 8'h16
`define RAIL4_VCODE_ADDR 8'h17
`define RAIL3_CTL_ADDR 8'h5E
`define RAIL4_CTL_ADDR 8'h60
`define RAIL3_GRP_ADDR 8'hF0
`define RAIL4_GRP_ADDR 8'hF1

// Control register fields
`define CTL_EN_BIT 0
`define CTL_SEL_BIT 1
`define CTL_RESET 2'h0

// Voltage code field
`define VCODE_MSB 5
`define VCODE_RESET 6'h00
`define VCODE_MAX 6'h1A
`define VOUT_BASE_MV 12'h3E8
`define VOUT_STEP_MV 12'h019

// Sequencing register fields
`define GRP_MSB 5
`define GRP_TYPE_MSB 5
`define GRP_TYPE_LSB 4
`define GRP_GROUP_MSB 3
`define GRP_GROUP_LSB 0
`define GRP_RESET 6'h00
`define GROUP_LAST 4'hE

// Bus framing
`define BYTE_BITS 4'h8
`define BYTE_ZERO 8'h00
`define BIT_ONE 4'h1

`endif

// ===== rail_pkg.sv
// Types and shared arithmetic for the rail control bank
`include "rail_params.svh"
`default_nettype none

package rail_pkg;

    // Rail class as used by the power sequencer
    typedef enum logic [1:0] {
        CLASS_A = 2'b00,
        CLASS_U = 2'b01,
        CLASS_S = 2'b10,
        CLASS_SX = 2'b11
    } rail_class_t;

    // Serial slave protocol phases
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_PTR = 4'b0011,
        ST_PTR_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } i2c_state_t;

    // Target output in millivolts for a voltage code
    function automatic logic [11:0] vcode_to_mv(input logic [5:0] code);
        vcode_to_mv = `VOUT_BASE_MV + 12'(code) * `VOUT_STEP_MV;
    endfunction : vcode_to_mv

endpackage : rail_pkg

`default_nettype wire

// ===== rail_select.sv
// Per-rail on/off selection, target voltage and sequencing field decode
`include "rail_params.svh"
`default_nettype none

module rail_select
    import rail_pkg::*;
#(
    parameter bit SEQ_INVERT = 1'b0
) (
    // Clock and synchronised reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register fields
    input wire logic source_select_i,
    input wire logic software_enable_i,
    input wire logic [`VCODE_MSB:0] vcode_i,
    input wire logic [`GRP_MSB:0] grp_i,
    // Sequencer request, same clock domain
    input wire logic seq_on_i,
    // Rail outputs
    output logic rail_on_o,
    output logic [11:0] target_mv_o,
    output logic mv_in_range_o,
    output rail_class_t class_o,
    output logic [3:0] group_o
);

    // On/off source: software bit or sequencer request
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rail_on_o <= 1'b0;
        end else if (source_select_i) begin
            rail_on_o <= software_enable_i;
        end else begin
            rail_on_o <= seq_on_i ^ SEQ_INVERT;
        end
    end

    // Linear code to millivolt; codes past the table are flagged
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target_mv_o <= `VOUT_BASE_MV;
            mv_in_range_o <= 1'b1;
        end else begin
            target_mv_o <= vcode_to_mv(vcode_i);
            mv_in_range_o <= (vcode_i <= `VCODE_MAX);
        end
    end

    // Sequencing fields handed to the sequencer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            class_o <= CLASS_A;
            group_o <= 4'h0;
        end else begin
            class_o <= rail_class_t'(grp_i[`GRP_TYPE_MSB:`GRP_TYPE_LSB]);
            group_o <= grp_i[`GRP_GROUP_MSB:`GRP_GROUP_LSB];
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_software_drives_rail: assert property (
        source_select_i |=> rail_on_o == $past(software_enable_i))
        else $error("rail does not follow software enable");

    a_sequencer_drives_rail: assert property (
        rst_n_i && !source_select_i ##1 !source_select_i
        |-> rail_on_o == ($past(seq_on_i) ^ SEQ_INVERT))
        else $error("rail does not follow sequencer");

    a_voltage_linear: assert property (
        1'b1 |=> target_mv_o ==
            `VOUT_BASE_MV + 12'($past(vcode_i)) * `VOUT_STEP_MV)
        else $error("target voltage not linear in code");

    a_top_code_range: assert property (
        vcode_i == `VCODE_MAX |=> mv_in_range_o && target_mv_o == 12'h672)
        else $error("top code does not give 1650 mV");

    a_class_decode: assert property (
        grp_i[`GRP_TYPE_MSB:`GRP_TYPE_LSB] == 2'h3 |=> class_o == CLASS_SX)
        else $error("rail class decode wrong");

    a_group_number: assert property (
        1'b1 |=> group_o == $past(grp_i[`GRP_GROUP_MSB:`GRP_GROUP_LSB]))
        else $error("group number not passed through");

    c_seq_turns_on: cover property (
        !source_select_i && seq_on_i ##1 $rose(rail_on_o));
    c_sw_turns_on: cover property (
        source_select_i && software_enable_i ##1 $rose(rail_on_o));

endmodule : rail_select

`default_nettype wire

// ===== i2c_host.sv
// Serial bus host model that drives the rail bank's register pins
`default_nettype none

module i2c_host #(
    parameter logic [6:0] DEV = 7'h2A // Arbitrary bus address
) (
    // Clock and resolved data wire
    input wire logic clock_i,
    input wire logic sda_i,
    // Host pin drives, SDA is pulled low only, never driven high
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Quarter bit; lines move only mid-phase so the filters never race
    task automatic q();
        repeat (5) @(posedge clock_i);
        #1;
    endtask : q

    // Start or repeated start, entered with SCL low or idle
    task automatic start();
        q();
        sda_low_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        q();
        sda_low_o = 1'b1;
        q();
        q();
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        q();
        sda_low_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        q();
        sda_low_o = 1'b0;
        q();
        q();
    endtask : stop

    // Eight bits MSB first then the acknowledge slot; sampled at SCL fall
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            q();
            sda_low_o = ~tx[i];
            q();
            scl_o = 1'b1;
            q();
            q();
            rx[i] = sda_i;
            scl_o = 1'b0;
        end
    endtask : xfer

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] d, output logic ok);
        logic [8:0] r0, r1, r2;
        start();
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({ptr, 1'b1}, r1);
        xfer({d, 1'b1}, r2);
        stop();
        ok = ~r0[0] & ~r1[0] & ~r2[0];
    endtask : wr

    // Single byte read, last byte refused with a high acknowledge
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic [8:0] r;
        start();
        xfer({DEV, 1'b0, 1'b1}, r);
        xfer({ptr, 1'b1}, r);
        start();
        xfer({DEV, 1'b1, 1'b1}, r);
        xfer(9'h1FF, r);
        stop();
        d = r[8:1];
    endtask : rd
endmodule : i2c_host

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the two-rail register bank
`default_nettype none

module tb
    import rail_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0, rstn_i = 1'b0, seq3 = 1'b0, seq4 = 1'b0;
    logic scl, sda_low, sda_oe, sda_d, ok;
    logic on3, on4, inr3, inr4;
    logic [5:0] vc3, vc4;
    logic [11:0] mv3, mv4;
    rail_class_t cl3, cl4;
    logic [3:0] gr3, gr4;
    int n_mismatch = 0, total_checks = 0;
    // Pull-up unless someone pulls low; a device data bit of 1 would show
    wire sda = ~sda_low & (~sda_oe | sda_d);
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    i2c_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(sda_low));
    ldo_rail_control_regs dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe),
        .otp_rail3_vcode_i(6'h08), .otp_rail4_vcode_i(6'h0C),
        .otp_rail3_grp_i(6'h25), .otp_rail4_grp_i(6'h1E),
        .rail3_seq_on_i(seq3), .rail4_seq_on_i(seq4),
        .rail3_on_o(on3), .rail3_vcode_o(vc3), .rail3_target_mv_o(mv3),
        .rail3_mv_in_range_o(inr3), .rail3_class_o(cl3),
        .rail3_group_o(gr3), .rail4_on_o(on4), .rail4_vcode_o(vc4),
        .rail4_target_mv_o(mv4), .rail4_mv_in_range_o(inr4),
        .rail4_class_o(cl4), .rail4_group_o(gr4));

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Read a register back and compare the whole byte
    task automatic rc(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        host.rd(p, d);
        chk("register", {4'h0, e}, {4'h0, d});
    endtask : rc
    task automatic w(input logic [7:0] p, input logic [7:0] d);
        host.wr(7'h2A, p, d, ok);
        chk("ack", 12'h001, {11'h0, ok});
        cyc(3);
    endtask : w

    // Reset contents, OTP defaults and their decoded outputs
    task automatic t_reset();
        rc(8'h5E, 8'h00);
        rc(8'h60, 8'h00);
        rc(8'h16, 8'h08);
        rc(8'h17, 8'h0C);
        rc(8'hF0, 8'h25);
        rc(8'hF1, 8'h1E);
        chk("vcode", 12'h008, {6'h0, vc3});
        chk("class", 12'h002, {10'h0, cl3});
        chk("group", 12'h005, {8'h0, gr3});
        chk("vcode4", 12'h00C, {6'h0, vc4});
        chk("mv4", 12'h514, mv4);
        chk("range4", 12'h001, {11'h0, inr4});
    endtask : t_reset
    // Select clear: both rails track the sequencer request
    task automatic t_seq();
        seq3 = 1'b1;
        cyc(3);
        chk("on3", 12'h001, {11'h0, on3});
        chk("on4", 12'h000, {11'h0, on4});
        seq3 = 1'b0;
        seq4 = 1'b1;
        cyc(3);
        chk("on3", 12'h000, {11'h0, on3});
        chk("on4", 12'h001, {11'h0, on4});
    endtask : t_seq
    // Select set: enable bit wins over the sequencer both ways
    task automatic t_soft();
        seq3 = 1'b1;
        w(8'h5E, 8'h02);
        chk("on3", 12'h000, {11'h0, on3});
        seq3 = 1'b0;
        w(8'h5E, 8'h03);
        chk("on3", 12'h001, {11'h0, on3});
        seq4 = 1'b0;
        w(8'h60, 8'hFF);
        chk("on4", 12'h001, {11'h0, on4});
        rc(8'h60, 8'h03);
    endtask : t_soft
    // Voltage code bottom, top and one past the table's end
    task automatic t_vcode();
        logic [5:0] c;
        logic [5:0] codes [3] = '{6'h00, 6'h1A, 6'h1B};
        for (int i = 0; i < 3; i++) begin
            c = codes[i];
            w(8'h16, {2'b11, c});
            rc(8'h16, {2'b00, c});
            chk("mv", 12'h3E8 + 12'h019 * {6'h0, c}, mv3);
            chk("range", {11'h0, c <= 6'h1A}, {11'h0, inr3});
        end
    endtask : t_vcode
    // Every rail class with the last group number, reserved bits set
    task automatic t_grp();
        for (int t = 0; t < 4; t++) begin
            w(8'hF1, {2'b11, 2'(t), 4'hE});
            rc(8'hF1, {2'b00, 2'(t), 4'hE});
            chk("class", 12'(t), {10'h0, cl4});
            chk("group", 12'h00E, {8'h0, gr4});
        end
    endtask : t_grp
    // Unmapped place reads zero; a foreign bus address is not answered
    task automatic t_refuse();
        w(8'h20, 8'h5A);
        rc(8'h20, 8'h00);
        host.wr(7'h2B, 8'h5E, 8'h00, ok);
        chk("ack", 12'h000, {11'h0, ok});
        rc(8'h5E, 8'h03);
    endtask : t_refuse

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog at 50k cycles, well above the expected run of about 20k
    initial begin
        #1000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        cyc(10);
        rstn_i = 1'b1;
        cyc(6);
        t_reset();
        t_seq();
        t_soft();
        t_vcode();
        t_grp();
        t_refuse();
        end_of_test();
    end
endmodule : tb

`default_nettype wire
